// ### drcr_pkg.sv
// Shared constants and types of the run-command register block
package drcr_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned SW_W   = 8;

    // Holding register numbers
    localparam logic [15:0] REG_MODEL       = 16'h000e;
    localparam logic [15:0] REG_FIRMWARE    = 16'h000f;
    localparam logic [15:0] RSV_STATUS_LO   = 16'h0010;
    localparam logic [15:0] RSV_STATUS_HI   = 16'h001f;
    localparam logic [15:0] REG_RUN_WORD    = 16'h0020;
    localparam logic [15:0] REG_GOAL_HIGH   = 16'h0021;
    localparam logic [15:0] REG_GOAL_LOW    = 16'h0022;
    localparam logic [15:0] RSV_COMMAND_LO  = 16'h0023;
    localparam logic [15:0] RSV_COMMAND_HI  = 16'h0025;
    localparam logic [15:0] REG_NODE_ADDR   = 16'h0026;
    localparam logic [15:0] REG_PARAM_SAVE  = 16'h0074;

    // Run command word fields
    localparam int unsigned RUN_UP          = 0;
    localparam int unsigned RUN_DOWN        = 1;
    localparam int unsigned RUN_JOG_CONT    = 3;
    localparam int unsigned RUN_RELEASE     = 4;
    localparam int unsigned RUN_EXT_KEYS    = 5;
    localparam int unsigned RUN_NO_LOOP     = 6;
    localparam int unsigned RUN_REF_LOOP    = 7;
    localparam int unsigned RUN_BUS_JOG_UP  = 8;
    localparam int unsigned RUN_BUS_JOG_DN  = 9;
    localparam int unsigned RUN_READJUST    = 10;
    localparam int unsigned RUN_BRAKE_FREE  = 11;
    localparam int unsigned RUN_DRAG_CORR   = 12;
    localparam logic [15:0] RUN_DEFINED     = 16'h1ffb;

    // Reset values and limits
    localparam logic [15:0] RUN_RESET       = 16'h0000;
    localparam logic [15:0] GOAL_RESET      = 16'h0000;
    localparam logic [15:0] NODE_RESET      = 16'h0001;
    localparam logic [15:0] NODE_MIN        = 16'h0001;
    localparam logic [15:0] NODE_MAX        = 16'h00f7;
    localparam logic [15:0] SAVE_COMMAND    = 16'h0001;
    localparam logic [15:0] READ_ZERO       = 16'h0000;
    localparam logic [7:0]  SWITCH_OFF      = 8'h00;

    typedef enum logic {DRCR_BOOT, DRCR_LIVE} drcr_phase_t;

    function automatic logic drcr_in_range(input logic [15:0] a,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
        drcr_in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

// ### drcr_node_store.sv
// Backed-up bus address store: staged, saved and active copies
`timescale 1ns/100ps
module drcr_node_store
    import drcr_pkg::*;
(
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    // Staging and save requests
    input  wire logic        stage_we,
    input  wire logic [15:0] stage_data,
    input  wire logic        save,
    // Stored values
    output logic      [15:0] staged,
    output logic      [15:0] saved,
    output logic      [15:0] active
);

    typedef struct packed {
        drcr_phase_t phase;
        logic [15:0] staged;
        logic [15:0] active;
    } drcr_store_t;

    drcr_store_t state;
    drcr_store_t next_state;
    logic [15:0] saved_q;

    // Saved copy survives restarts; only power-on sets it back to NODE_RESET
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            saved_q <= NODE_RESET;
        else if (save)
            saved_q <= state.staged;
    end

    always_comb
    begin
        next_state = state;
        if (state.phase == DRCR_BOOT)
        begin
            // Restart picks up what was saved last
            next_state.phase  = DRCR_LIVE;
            next_state.staged = saved_q;
            next_state.active = saved_q;
        end
        else if (stage_we)
        begin
            next_state.staged = stage_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state.phase  <= DRCR_BOOT;
            state.staged <= NODE_RESET;
            state.active <= NODE_RESET;
        end
        else
            state <= next_state;
    end

    assign staged = state.staged;
    assign saved  = saved_q;
    assign active = state.active;

endmodule

// ### drcr_run_regs.sv
// Run command, goal position and bus address holding registers
//
// Functional notes
// - Model identification register, read only, sixteen bits unsigned.
// - Firmware version register, read only, sixteen bits unsigned.
// - Bit 0 runs toward larger values, bit 1 toward smaller; bit 2 reserved.
// - Jog key mode runs continuously only with bit 3; otherwise single steps.
// - Motion needs release bit 4, except jog key mode by keys or bits 8/9.
// - With bus active, external jog keys count only when bit 5 is set.
// - Bit 6 runs without approach loop; bit 7 starts reference loop run.
// - Bit 10 readjustment, bit 11 braking-free run, bit 12 drag correction.
// - Goal position is 32-bit signed, high then low word, zero default.
// - Goal position counts hundredths of a millimetre with default scaling.
// - Bus address is saved, writable, accepts 1 to 247, defaults to 1.
// - Address switches above 00 block writes to the bus address.
// - New address applies only after parameter save and a restart.
`timescale 1ns/100ps
module drcr_run_regs
    import drcr_pkg::*;
#(
    parameter logic [15:0] MODEL_ID    = 16'h1234, // Arbitrary value
    parameter logic [15:0] FW_VERSION  = 16'h0100  // Arbitrary value
)
(
    // Clock and resets
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    por_n,
    // Register access from the frame decoder
    input  wire logic                    acc_valid,
    input  wire logic                    acc_write,
    input  wire logic [15:0]             acc_addr,
    input  wire logic [drcr_pkg::DATA_W-1:0] acc_wdata,
    output logic                         acc_done,
    output logic                         acc_refused,
    output logic [drcr_pkg::DATA_W-1:0]  acc_rdata,
    // Drive context
    input  wire logic                    bus_active,
    input  wire logic                    jog_key_mode,
    input  wire logic [drcr_pkg::SW_W-1:0] addr_switch,
    input  wire logic                    key_up,
    input  wire logic                    key_down,
    // Commands to motion control
    output logic                         run_up,
    output logic                         run_down,
    output logic                         step_up,
    output logic                         step_down,
    output logic                         motion_allowed,
    output logic                         run_no_loop,
    output logic                         ref_loop_start,
    output logic                         readjust_enable,
    output logic                         brake_free_run,
    output logic                         drag_correction,
    output logic signed [31:0]           goal_position,
    // Bus address in use and parameter-save flag
    output logic [15:0]                  node_address,
    output logic                         param_saved
);

    typedef struct packed {
        logic [15:0] run_word;
        logic [15:0] goal_high;
        logic [15:0] goal_low;
        logic [31:0] goal_pos;
        logic        done;
        logic        refused;
        logic [15:0] rdata;
        logic [7:0]  sw_s1;
        logic [7:0]  sw_s2;
        logic [1:0]  key_s1;
        logic [1:0]  key_s2;
        logic [1:0]  jog_prev;
        logic        run_up;
        logic        run_down;
        logic        step_up;
        logic        step_down;
        logic        motion;
        logic        no_loop;
        logic        ref_loop;
        logic        readjust;
        logic        brake_free;
        logic        drag_corr;
        logic        save;
        logic        saved_flag;
        logic        node_we;
        logic [15:0] node_wdata;
    } drcr_state_t;

    drcr_state_t state;
    drcr_state_t next_state;

    logic [15:0] node_staged;
    logic [15:0] node_saved;
    logic [15:0] node_active;

    drcr_node_store drcr_node_store_i (
        .clk        (clk),
        .rst_n      (rst_n),
        .por_n      (por_n),
        .stage_we   (state.node_we),
        .stage_data (state.node_wdata),
        .save       (state.save),
        .staged     (node_staged),
        .saved      (node_saved),
        .active     (node_active)
    );

    logic        keys_honoured;
    logic        key_up_eff;
    logic        key_dn_eff;
    logic        bus_up;
    logic        bus_dn;
    logic        jog_up_req;
    logic        jog_dn_req;
    logic        continuous;
    logic        release_bit;
    logic        rsv_addr;
    logic        switches_set;
    logic [15:0] wr_run;

    always_comb
    begin
        next_state = state;

        // Address switches and keys pass two flops before use
        next_state.sw_s1  = addr_switch;
        next_state.sw_s2  = state.sw_s1;
        next_state.key_s1 = {key_down, key_up};
        next_state.key_s2 = state.key_s1;

        release_bit  = state.run_word[RUN_RELEASE];
        switches_set = (state.sw_s2 != SWITCH_OFF);

        // External keys are muted by the bus unless bit 5 frees them
        keys_honoured = jog_key_mode
                        && (!bus_active || state.run_word[RUN_EXT_KEYS]);
        key_up_eff    = keys_honoured && state.key_s2[0];
        key_dn_eff    = keys_honoured && state.key_s2[1];
        bus_up        = jog_key_mode && state.run_word[RUN_BUS_JOG_UP];
        bus_dn        = jog_key_mode && state.run_word[RUN_BUS_JOG_DN];
        jog_up_req    = key_up_eff || bus_up;
        jog_dn_req    = key_dn_eff || bus_dn;
        continuous    = state.run_word[RUN_JOG_CONT];

        // Both directions at once cancel each other out
        if (jog_key_mode)
        begin
            next_state.run_up   = jog_up_req && !jog_dn_req && continuous;
            next_state.run_down = jog_dn_req && !jog_up_req && continuous;
        end
        else
        begin
            next_state.run_up   = release_bit && state.run_word[RUN_UP]
                                  && !state.run_word[RUN_DOWN];
            next_state.run_down = release_bit && state.run_word[RUN_DOWN]
                                  && !state.run_word[RUN_UP];
        end

        // A single step fires on each fresh press when not continuous
        next_state.jog_prev  = {jog_dn_req, jog_up_req};
        next_state.step_up   = jog_key_mode && !continuous
                               && jog_up_req && !state.jog_prev[0];
        next_state.step_down = jog_key_mode && !continuous
                               && jog_dn_req && !state.jog_prev[1];

        next_state.motion = release_bit
                            || (jog_key_mode && (key_up_eff || key_dn_eff
                                                 || bus_up || bus_dn));

        next_state.no_loop    = state.run_word[RUN_NO_LOOP];
        next_state.ref_loop   = state.run_word[RUN_REF_LOOP];
        next_state.readjust   = state.run_word[RUN_READJUST];
        next_state.brake_free = state.run_word[RUN_BRAKE_FREE];
        next_state.drag_corr  = state.run_word[RUN_DRAG_CORR];

        // Scaling is applied downstream; the raw count is passed on
        next_state.goal_pos = {state.goal_high, state.goal_low};

        // Register access, answered one cycle later
        next_state.done    = 1'b0;
        next_state.refused = 1'b0;
        next_state.save    = 1'b0;
        next_state.node_we = 1'b0;
        rsv_addr = drcr_in_range(acc_addr, RSV_STATUS_LO, RSV_STATUS_HI)
                   || drcr_in_range(acc_addr, RSV_COMMAND_LO, RSV_COMMAND_HI);
        // Undefined bits are dropped in case the master sends them anyway
        wr_run = acc_wdata & RUN_DEFINED;

        if (acc_valid)
        begin
            next_state.done  = 1'b1;
            next_state.rdata = READ_ZERO;
            if (acc_write)
            begin
                unique case (acc_addr)
                    REG_RUN_WORD:
                    begin
                        next_state.run_word = wr_run;
                    end
                    REG_GOAL_HIGH:
                    begin
                        next_state.goal_high = acc_wdata;
                    end
                    REG_GOAL_LOW:
                    begin
                        next_state.goal_low = acc_wdata;
                    end
                    REG_NODE_ADDR:
                    begin
                        if (switches_set)
                            next_state.refused = 1'b1;
                        else if (!drcr_in_range(acc_wdata, NODE_MIN, NODE_MAX))
                            next_state.refused = 1'b1;
                        else
                        begin
                            next_state.node_we    = 1'b1;
                            next_state.node_wdata = acc_wdata;
                        end
                    end
                    REG_PARAM_SAVE:
                    begin
                        next_state.save = (acc_wdata == SAVE_COMMAND);
                    end
                    default:
                    begin
                        // Read-only, reserved and unknown registers keep their contents
                        next_state.refused = 1'b1;
                    end
                endcase
            end
            else
            begin
                unique case (acc_addr)
                    REG_MODEL:      next_state.rdata = MODEL_ID;
                    REG_FIRMWARE:   next_state.rdata = FW_VERSION;
                    REG_RUN_WORD:   next_state.rdata = state.run_word;
                    REG_GOAL_HIGH:  next_state.rdata = state.goal_high;
                    REG_GOAL_LOW:   next_state.rdata = state.goal_low;
                    REG_NODE_ADDR:  next_state.rdata = node_staged;
                    REG_PARAM_SAVE: next_state.rdata = READ_ZERO;
                    default:
                    begin
                        next_state.rdata   = READ_ZERO;
                        next_state.refused = !rsv_addr;
                    end
                endcase
            end
        end

        // Sticky until restart: tells that a new address is waiting
        if (state.save)
            next_state.saved_flag = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state            <= '0;
            state.run_word   <= RUN_RESET;
            state.goal_high  <= GOAL_RESET;
            state.goal_low   <= GOAL_RESET;
            state.node_wdata <= NODE_RESET;
            state.rdata      <= READ_ZERO;
        end
        else
            state <= next_state;
    end

    assign acc_done        = state.done;
    assign acc_refused     = state.refused;
    assign acc_rdata       = state.rdata;
    assign run_up          = state.run_up;
    assign run_down        = state.run_down;
    assign step_up         = state.step_up;
    assign step_down       = state.step_down;
    assign motion_allowed  = state.motion;
    assign run_no_loop     = state.no_loop;
    assign ref_loop_start  = state.ref_loop;
    assign readjust_enable = state.readjust;
    assign brake_free_run  = state.brake_free;
    assign drag_correction = state.drag_corr;
    assign goal_position   = signed'(state.goal_pos);
    assign node_address    = node_active;
    assign param_saved     = state.saved_flag;

endmodule

// ### drcr_run_regs_checker.sv
// Concurrent checks on the ports of the run-command register block
`timescale 1ns/100ps
module drcr_run_regs_checker
    import drcr_pkg::*;
#(
    parameter logic [15:0] MODEL_ID   = 16'h1234,
    parameter logic [15:0] FW_VERSION = 16'h0100
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Register access
    input  wire logic               acc_valid,
    input  wire logic               acc_write,
    input  wire logic [15:0]        acc_addr,
    input  wire logic [15:0]        acc_wdata,
    input  wire logic               acc_done,
    input  wire logic               acc_refused,
    input  wire logic [15:0]        acc_rdata,
    // Commands and address
    input  wire logic               run_up,
    input  wire logic               run_down,
    input  wire logic               step_up,
    input  wire logic               motion_allowed,
    input  wire logic signed [31:0] goal_position,
    input  wire logic [15:0]        node_address
);
    logic [1:0] up_cnt;
    logic       rd;
    logic       wr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign rd = acc_valid && !acc_write;
    assign wr = acc_valid && acc_write;
    // Node address may still settle on the first three edges after a restart
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    a_model_read: assert property (
        rd && acc_addr == REG_MODEL |=> acc_done && !acc_refused && acc_rdata == MODEL_ID)
        else $error("model register read wrong");
    a_fw_read: assert property (
        rd && acc_addr == REG_FIRMWARE |=> acc_done && acc_rdata == FW_VERSION)
        else $error("firmware register read wrong");
    a_dir_exclusive: assert property (!(run_up && run_down))
        else $error("both run directions at once");
    a_step_single: assert property (step_up |=> !step_up)
        else $error("step pulse longer than one cycle");
    a_release_gate: assert property (!motion_allowed |-> !run_up && !run_down)
        else $error("run without motion release");
    a_goal_low: assert property (
        wr && acc_addr == REG_GOAL_LOW |-> ##2 goal_position[15:0] == $past(acc_wdata, 2))
        else $error("goal low word not applied");
    a_node_range: assert property (
        wr && acc_addr == REG_NODE_ADDR && (acc_wdata < NODE_MIN || acc_wdata > NODE_MAX)
        |=> acc_done && acc_refused)
        else $error("out of range address accepted");
    a_node_held: assert property (
        wr && acc_addr == REG_NODE_ADDR && up_cnt == 2'h3 |=> $stable(node_address) [*3])
        else $error("address in use changed without restart");
    a_ro_refused: assert property (
        wr && (acc_addr == REG_MODEL || acc_addr == REG_FIRMWARE) |=> acc_done && acc_refused)
        else $error("write to read-only register accepted");
    a_reserved_zero: assert property (
        rd && ((acc_addr >= RSV_STATUS_LO && acc_addr <= RSV_STATUS_HI)
        || (acc_addr >= RSV_COMMAND_LO && acc_addr <= RSV_COMMAND_HI))
        |=> acc_done && !acc_refused && acc_rdata == READ_ZERO)
        else $error("reserved register not read as zero");
    c_model: cover property (rd && acc_addr == REG_MODEL);
    c_step: cover property (step_up);
    c_node_refused: cover property (wr && acc_addr == REG_NODE_ADDR ##1 acc_refused);
endmodule

bind drcr_run_regs drcr_run_regs_checker #(.MODEL_ID(MODEL_ID), .FW_VERSION(FW_VERSION))
    drcr_run_regs_checker_i (.clk(clk), .rst_n(rst_n), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_refused(acc_refused), .acc_rdata(acc_rdata),
    .run_up(run_up), .run_down(run_down), .step_up(step_up),
    .motion_allowed(motion_allowed), .goal_position(goal_position),
    .node_address(node_address));

// ### drcr_bus_master.sv
// Bus master model issuing single register accesses to the block
`timescale 1ns/100ps
module drcr_bus_master
    import drcr_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Access request
    output logic             acc_valid,
    output logic             acc_write,
    output logic [15:0]      acc_addr,
    output logic [15:0]      acc_wdata,
    // Answer
    input  wire logic        acc_done,
    input  wire logic        acc_refused,
    input  wire logic [15:0] acc_rdata
);
    initial
    begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 16'hffff;
        acc_wdata = 16'hffff;
    end
    // Idle lines carry the inverse of the last request so stale values never match
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rdat, output logic refused);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_addr  <= a;
        acc_wdata <= (a == REG_RUN_WORD) ? (d & RUN_DEFINED) : d;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_write <= ~w;
        acc_addr  <= ~a;
        acc_wdata <= ~d;
        #1;
        rdat = (acc_done === 1'b1) ? acc_rdata : 16'hdead;
        refused = acc_refused;
    endtask
endmodule

// ### drcr_run_regs_tb.sv
// Self-checking bench of the run-command register block
`timescale 1ns/100ps
module drcr_run_regs_tb;
    import drcr_pkg::*;
    localparam logic [15:0] MODEL_ID   = 16'h3a7c; // Arbitrary value
    localparam logic [15:0] FW_VERSION = 16'h0205; // Arbitrary value
    localparam logic [15:0] RO [6] = '{16'h000e, 16'h000f, 16'h0010, 16'h001f, 16'h0023,
                                       16'h0025};
    logic        clk, rst_n, por_n, bus_active, jog_key_mode, key_up, key_down;
    logic        acc_valid, acc_write, acc_done, acc_refused, rf, param_saved;
    logic [15:0] acc_addr, acc_wdata, acc_rdata, rd, w, node_address;
    logic        run_up, run_down, step_up, motion_allowed, run_no_loop, ref_loop_start;
    logic        readjust_enable, brake_free_run, drag_correction;
    logic [7:0]  addr_switch, cmd;
    logic [31:0] g;
    logic signed [31:0] goal_position;
    int          n_mismatch, total_checks, n_step, n_dn;
    logic        step_down;
    assign cmd = {run_up, run_down, motion_allowed, run_no_loop, ref_loop_start,
                  readjust_enable, brake_free_run, drag_correction};
    drcr_run_regs #(.MODEL_ID(MODEL_ID), .FW_VERSION(FW_VERSION)) drcr_run_regs_i (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_done(acc_done), .acc_refused(acc_refused), .acc_rdata(acc_rdata),
        .bus_active(bus_active), .jog_key_mode(jog_key_mode), .addr_switch(addr_switch),
        .key_up(key_up), .key_down(key_down), .run_up(run_up), .run_down(run_down),
        .step_up(step_up), .step_down(step_down), .motion_allowed(motion_allowed),
        .run_no_loop(run_no_loop), .ref_loop_start(ref_loop_start),
        .readjust_enable(readjust_enable), .brake_free_run(brake_free_run),
        .drag_correction(drag_correction), .goal_position(goal_position),
        .node_address(node_address), .param_saved(param_saved));
    drcr_bus_master drcr_bus_master_i (.clk(clk), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_done(acc_done), .acc_refused(acc_refused), .acc_rdata(acc_rdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
        if (step_up === 1'b1)
            n_step <= n_step + 1;
    always @(posedge clk)
        if (step_down === 1'b1)
            n_dn <= n_dn + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic r);
        drcr_bus_master_i.xfer(1'b0, a, 16'h0000, rd, rf);
        check({rd, rf}, {exp, r});
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic r);
        drcr_bus_master_i.xfer(1'b1, a, d, rd, rf);
        check(rf, r);
    endtask
    // Command outputs outside jog key mode, in the order of cmd
    function automatic logic [7:0] exp_cmd(input logic [15:0] v);
        exp_cmd = {v[4] & v[0] & ~v[1], v[4] & v[1] & ~v[0], v[4], v[6], v[7], v[10],
                   v[11], v[12]};
    endfunction
    initial
    begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        n_mismatch = 0;
        total_checks = 0;
        n_step = 0;
        n_dn = 0;
        rst_n = 1'b0;
        por_n = 1'b0;
        bus_active = 1'b0;
        jog_key_mode = 1'b0;
        key_up = 1'b0;
        key_down = 1'b0;
        addr_switch = 8'h00;
        void'($urandom(37384));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        settle(2);
        check(node_address, NODE_RESET);
        rd_chk(REG_GOAL_HIGH, GOAL_RESET, 1'b0);
        rd_chk(REG_GOAL_LOW, GOAL_RESET, 1'b0);
        rd_chk(REG_MODEL, MODEL_ID, 1'b0);
        rd_chk(REG_FIRMWARE, FW_VERSION, 1'b0);
        foreach (RO[i])
        begin
            wr(RO[i], 16'($urandom), 1'b1);
            rd_chk(RO[i], i == 0 ? MODEL_ID : (i == 1 ? FW_VERSION : READ_ZERO), 1'b0);
        end
        rd_chk(16'h0050, READ_ZERO, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            g = (i == 0) ? 32'h80000000 : ((i == 1) ? 32'hffffffff : $urandom);
            wr(REG_GOAL_HIGH, g[31:16], 1'b0);
            wr(REG_GOAL_LOW, g[15:0], 1'b0);
            settle(1);
            check(goal_position, g);
            rd_chk(REG_GOAL_HIGH, g[31:16], 1'b0);
        end
        for (int i = 0; i < 24; i++)
        begin
            w = (i < 13) ? (16'h0010 | (16'h0001 << i)) : 16'($urandom);
            wr(REG_RUN_WORD, w, 1'b0);
            settle(1);
            w = w & RUN_DEFINED;
            check(cmd, exp_cmd(w));
            rd_chk(REG_RUN_WORD, w, 1'b0);
        end
        @(posedge clk);
        jog_key_mode <= 1'b1;
        bus_active <= 1'b1;
        key_up <= 1'b1;
        wr(REG_RUN_WORD, 16'h0008, 1'b0);
        settle(4);
        check({run_up, motion_allowed}, 2'b00);
        wr(REG_RUN_WORD, 16'h0028, 1'b0);
        settle(1);
        check({run_up, motion_allowed}, 2'b11);
        key_up <= 1'b0;
        wr(REG_RUN_WORD, 16'h0020, 1'b0);
        settle(4);
        n_step = 0;
        key_up <= 1'b1;
        settle(6);
        check(n_step, 1);
        check(run_up, 1'b0);
        key_up <= 1'b0;
        key_down <= 1'b1;
        settle(6);
        check(n_dn, 1);
        check(run_down, 1'b0);
        key_down <= 1'b0;
        wr(REG_RUN_WORD, 16'h0108, 1'b0);
        settle(4);
        check({run_up, motion_allowed}, 2'b11);
        jog_key_mode <= 1'b0;
        wr(REG_NODE_ADDR, 16'h0000, 1'b1);
        wr(REG_NODE_ADDR, 16'h00f8, 1'b1);
        wr(REG_NODE_ADDR, NODE_MAX, 1'b0);
        wr(REG_PARAM_SAVE, SAVE_COMMAND, 1'b0);
        settle(2);
        check({param_saved, node_address}, {1'b1, NODE_RESET});
        rst_n <= 1'b0;
        settle(2);
        rst_n <= 1'b1;
        settle(3);
        check({param_saved, node_address}, {1'b0, NODE_MAX});
        addr_switch <= 8'h05;
        settle(3);
        wr(REG_NODE_ADDR, 16'h0010, 1'b1);
        conclude();
    end
endmodule
